/* File: tb/pri_core_model.sv */
`timescale 1ns/10ps
// ------------------------------
// Core fetch side of controller
// ------------------------------
module pri_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench controls
  input wire logic slow,
  input wire logic sleep,
  // Core side
  output logic core_boundary,
  output logic return_from_irq_instr,
  output logic core_asleep
);
  // Quiet core at time zero
  initial begin
    core_boundary = 1'b0;
    return_from_irq_instr = 1'b0;
    core_asleep = 1'b0;
  end
  // Boundary every cycle, or at random when stalling
  always @(posedge clk_sys) begin
    core_boundary <= reset_n && (!slow || $urandom_range(0, 1) == 1);
    core_asleep <= sleep;
  end
  // One-cycle return instruction
  task automatic ret();
    return_from_irq_instr <= 1'b1;
    @(posedge clk_sys);
    return_from_irq_instr <= 1'b0;
  endtask
endmodule

/* File: tb/priority_interrupt_controller_test.sv */
`timescale 1ns/10ps
`include "pri_params.svh"
module priority_interrupt_controller_test;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic timer0_ovf, ext_pin0_in, port_b_read, slow, sleep;
  logic [3:0] pins, port_b_input;
  logic [23:0] periph_evt;
  logic core_boundary, ret, asleep, irq_req, vec_load, stack_push, wake_req;
  logic [15:0] vec_addr;
  logic [7:0] r;
  int fail_count = 0;
  int cmp_count = 0;

  pri_ctrl #(.PREG_N(3)) pri_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_ovf(timer0_ovf), .ext_pin0_in(ext_pin0_in),
    .port_b_upper_pins(pins), .port_b_read(port_b_read), .periph_evt(periph_evt),
    .port_b_input(port_b_input), .core_boundary(core_boundary), .return_from_irq_instr(ret),
    .core_asleep(asleep), .irq_req(irq_req), .vec_load(vec_load), .stack_push(stack_push),
    .vec_addr(vec_addr), .wake_req(wake_req));
  pri_core_model pri_core_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
    .sleep(sleep), .core_boundary(core_boundary), .return_from_irq_instr(ret),
    .core_asleep(asleep));

  // ------------------------------
  // Clock, checks and bus tasks
  // ------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rdat);
  endtask
  // Wait for a vector load within a window of cycles
  task automatic wvec(input logic [15:0] e, input int lo, input int hi);
    int n;
    n = 0;
    while (vec_load !== 1'b1 && n < 30) begin
      @(negedge clk_sys);
      n++;
    end
    chk("vector", {16'h0, e}, {16'h0, vec_addr});
    chk("stack push", 32'h1, {31'h0, stack_push});
    chk("latency", 32'h1, {31'h0, (n >= lo && n <= hi)});
    @(posedge clk_sys);
  endtask
  task automatic novec();
    int s;
    s = 0;
    repeat (8) begin
      @(negedge clk_sys);
      if (vec_load !== 1'b0) s++;
    end
    @(posedge clk_sys);
    chk("no vector", 32'h0, 32'(s));
  endtask
  task automatic tpulse();
    timer0_ovf <= 1'b1;
    @(posedge clk_sys);
    timer0_ovf <= 1'b0;
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Watchdog and test sequence
  // ------------------------------
  initial begin
    #(40 * 4000);
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(70));
    {reset_n, psel, penable, pwrite, timer0_ovf, ext_pin0_in, port_b_read, slow, sleep} = '0;
    paddr = '0;
    pwdata = '0;
    pins = '0;
    periph_evt = '0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd("main reset", `PRI_OFF_MAIN, `PRI_RST_MAIN);
    rd("mode reset", `PRI_OFF_RCTL, 8'h00);
    rd("second reset", `PRI_OFF_SECOND, `PRI_RST_SECOND);
    rd("unmapped", 12'h040, 8'h00);
    chk("slverr", 32'h1, {31'h0, rerr});
    $display("test reset done");
    // Flags set with every enable off
    pins <= 4'($urandom_range(1, 15));
    tpulse();
    novec();
    rd("polled flags", `PRI_OFF_MAIN, 8'h05);
    chk("port value", {28'h0, pins}, {28'h0, port_b_input});
    port_b_read <= 1'b1;
    @(posedge clk_sys);
    port_b_read <= 1'b0;
    apb(1'b1, `PRI_OFF_MAIN, 8'h00);
    rd("flags cleared", `PRI_OFF_MAIN, 8'h00);
    $display("test polling done");
    // Compatibility mode, single vector
    apb(1'b1, `PRI_OFF_MAIN, 8'hA0);
    tpulse();
    wvec(`PRI_VEC_HIGH, 1, 4);
    rd("single enable cleared", `PRI_OFF_MAIN, 8'h24);
    apb(1'b1, `PRI_OFF_MAIN, 8'h20);
    pri_core_model_inst.ret();
    rd("single enable restored", `PRI_OFF_MAIN, 8'hA0);
    r = 8'($urandom_range(1, 255));
    apb(1'b1, `PRI_OFF_PEN, r);
    apb(1'b1, `PRI_OFF_MAIN, 8'h80);
    periph_evt <= {16'h0, r};
    @(posedge clk_sys);
    periph_evt <= '0;
    novec();
    rd("peripheral flags", `PRI_OFF_PFLAG, r);
    slow <= 1'b1;
    apb(1'b1, `PRI_OFF_MAIN, 8'hC0);
    wvec(`PRI_VEC_HIGH, 0, 30);
    slow <= 1'b0;
    apb(1'b1, `PRI_OFF_PFLAG, 8'h00);
    apb(1'b1, `PRI_OFF_PEN, 8'h00);
    // Leave the routine so priority mode starts idle
    pri_core_model_inst.ret();
    rd("peripheral enable restored", `PRI_OFF_MAIN, 8'hC0);
    $display("test compatibility done");
    // Priority mode, timer at low level
    apb(1'b1, `PRI_OFF_RCTL, 8'h80);
    apb(1'b1, `PRI_OFF_SECOND, 8'hFB);
    apb(1'b1, `PRI_OFF_MAIN, 8'h60);
    tpulse();
    sleep <= 1'b1;
    novec();
    chk("wake", 32'h1, {31'h0, wake_req});
    sleep <= 1'b0;
    apb(1'b1, `PRI_OFF_MAIN, 8'hE0);
    tpulse();
    wvec(`PRI_VEC_LOW, 1, 4);
    rd("low enable cleared", `PRI_OFF_MAIN, 8'hA4);
    rd("low active", `PRI_OFF_STATUS, 8'h01);
    // Rising pin edge preempts the low routine
    apb(1'b1, `PRI_OFF_MAIN, 8'hB0);
    ext_pin0_in <= 1'b1;
    wvec(`PRI_VEC_HIGH, 4, 6);
    rd("both active", `PRI_OFF_STATUS, 8'h03);
    rd("high enable cleared", `PRI_OFF_MAIN, 8'h32);
    apb(1'b1, `PRI_OFF_MAIN, 8'hE0);
    tpulse();
    novec();
    chk("no request in high", 32'h0, {31'h0, irq_req});
    $display("test priority done");
    close_out();
  end
endmodule

/* File: verilog/pri_ctrl.sv */
`timescale 1ns/10ps
// How it works
// - High vector 0008h, low vector 0018h
// - High request preempts running low routine
// - Each source has flag, enable, priority; pin fixed high
// - Priority mode only when mode bit set
// - Bit 7 high enable, bit 6 low enable
// - Flag, enable, global enable vector at next core boundary
// - Reset: compatibility mode, single vector 0008h
// - Compat: bit 6 peripherals, bit 7 all
// - Accepting clears the permitting global enable
// - No low accept during high routine
// - Accept pushes return, loads vector
// - Return instruction restores the global enable, except in a cycle that also accepts
// - Pin events vector within three-four cycles
// - Flags set regardless of any enable
// - Main bits 5,4,3 enable three sources
// - Bits 2,1 set by timer, pin
// - Bit 0 set by port mismatch
// - Priority mode: bit6 low off, bit7 all
// - Pin edge select, reset to rising
// - Three peripheral flag/enable/priority registers
module pri_ctrl
  import pri_pkg::*;
#(
  parameter int PREG_N = `PRI_PREG_N
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PRI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire logic timer0_ovf,
  input wire logic ext_pin0_in,
  input wire logic [3:0] port_b_upper_pins,
  input wire logic port_b_read,
  input wire logic [PREG_N*`PRI_PREG_W-1:0] periph_evt,
  output logic [3:0] port_b_input,
  // Core side
  input wire logic core_boundary,
  input wire logic return_from_irq_instr,
  input wire logic core_asleep,
  output logic irq_req,
  output logic vec_load,
  output logic stack_push,
  output logic [15:0] vec_addr,
  output logic wake_req
);

  localparam int PW = PREG_N * `PRI_PREG_W;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n_int;

  // Release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_r[1];

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  pri_state_t st_r;
  pri_state_t st_nxt;
  logic setup;
  logic wr;
  logic [2:0] core_act;
  logic [2:0] core_pri;
  logic [PW-1:0] p_act;
  logic hi_any;
  logic lo_any;
  logic hi_pend;
  logic lo_pend;
  logic accept;
  logic take_hi;
  logic x0_edge;
  logic pb_mismatch;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;

  // Per-source active terms: timer_zero, pin0, port change
  assign core_act = {st_r.main[`PRI_B_T0IF] & st_r.main[`PRI_B_T0IE],
                     st_r.main[`PRI_B_X0IF] & st_r.main[`PRI_B_X0IE],
                     st_r.main[`PRI_B_PCIF] & st_r.main[`PRI_B_PCIE]};
  assign core_pri = {st_r.second[`PRI_B_T0IP], 1'b1, st_r.second[`PRI_B_PCIP]};
  assign p_act = st_r.pflag & st_r.pen;

  // Level split by priority bit
  assign hi_any = (|(core_act & core_pri)) | (|(p_act & st_r.pprio));
  assign lo_any = (|(core_act & ~core_pri)) | (|(p_act & ~st_r.pprio));

  // Request generation for both modes
  always_comb begin
    if (st_r.priority_mode_enable) begin
      hi_pend = st_r.main[`PRI_B_HIGH_LEVEL_GLOBAL_ENABLE] & hi_any;
      lo_pend = st_r.main[`PRI_B_HIGH_LEVEL_GLOBAL_ENABLE] & st_r.main[`PRI_B_LOW_LEVEL_GLOBAL_ENABLE] & lo_any & ~st_r.hi_act;
    end else begin
      hi_pend = st_r.main[`PRI_B_HIGH_LEVEL_GLOBAL_ENABLE] & ((|core_act) | (st_r.main[`PRI_B_LOW_LEVEL_GLOBAL_ENABLE] & (|p_act)));
      lo_pend = 1'b0;
    end
  end

  assign irq_req = hi_pend | lo_pend;
  assign accept = core_boundary & irq_req;
  assign take_hi = hi_pend;

  // Pin edge, chosen by edge-select bit
  assign x0_edge = st_r.second[`PRI_B_X0EDGE] ? (st_r.x0_sync[1] & ~st_r.x0_prev)
                                              : (~st_r.x0_sync[1] & st_r.x0_prev);
  assign pb_mismatch = |(st_r.pb_s2 ^ st_r.pb_latch);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.vec_load = 1'b0;
    // Pin synchronisers and edge history
    st_nxt.x0_sync = {st_r.x0_sync[0], ext_pin0_in};
    st_nxt.x0_prev = st_r.x0_sync[1];
    st_nxt.pb_s1 = port_b_upper_pins;
    st_nxt.pb_s2 = st_r.pb_s1;
    // Port read ends the mismatch
    if (port_b_read) begin
      st_nxt.pb_latch = st_r.pb_s2;
    end
    // Register writes
    if (wr) begin
      case (paddr)
        `PRI_OFF_MAIN: st_nxt.main = pwdata[7:0];
        `PRI_OFF_RCTL: st_nxt.priority_mode_enable = pwdata[`PRI_B_PRIORITY_MODE_ENABLE];
        `PRI_OFF_SECOND: st_nxt.second = pwdata[7:0];
        default: begin
          for (int i = 0; i < PREG_N; i++) begin
            if (paddr == `PRI_OFF_PFLAG + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.pflag[i*`PRI_PREG_W +: `PRI_PREG_W] = pwdata[`PRI_PREG_W-1:0];
            end
            if (paddr == `PRI_OFF_PEN + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.pen[i*`PRI_PREG_W +: `PRI_PREG_W] = pwdata[`PRI_PREG_W-1:0];
            end
            if (paddr == `PRI_OFF_PPRIO + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.pprio[i*`PRI_PREG_W +: `PRI_PREG_W] = pwdata[`PRI_PREG_W-1:0];
            end
          end
        end
      endcase
    end
    // Hardware sets win over software clears
    if (timer0_ovf) begin
      st_nxt.main[`PRI_B_T0IF] = 1'b1;
    end
    if (x0_edge) begin
      st_nxt.main[`PRI_B_X0IF] = 1'b1;
    end
    if (pb_mismatch) begin
      st_nxt.main[`PRI_B_PCIF] = 1'b1;
    end
    st_nxt.pflag = st_nxt.pflag | periph_evt;
    // Accept: vector, clear the permitting enable
    if (accept) begin
      st_nxt.vec_load = 1'b1;
      if (take_hi) begin
        st_nxt.vec_addr = `PRI_VEC_HIGH;
        st_nxt.main[`PRI_B_HIGH_LEVEL_GLOBAL_ENABLE] = 1'b0;
        st_nxt.hi_act = 1'b1;
      end else begin
        st_nxt.vec_addr = `PRI_VEC_LOW;
        st_nxt.main[`PRI_B_LOW_LEVEL_GLOBAL_ENABLE] = 1'b0;
        st_nxt.lo_act = 1'b1;
      end
    end else if (return_from_irq_instr) begin
      // Leave innermost routine, restore its enable
      if (st_r.hi_act) begin
        st_nxt.main[`PRI_B_HIGH_LEVEL_GLOBAL_ENABLE] = 1'b1;
        st_nxt.hi_act = 1'b0;
      end else if (st_r.lo_act) begin
        st_nxt.main[`PRI_B_LOW_LEVEL_GLOBAL_ENABLE] = 1'b1;
        st_nxt.lo_act = 1'b0;
      end
    end
    // Read data captured in setup cycle
    if (setup) begin
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.slverr = 1'b0;
      case (paddr)
        `PRI_OFF_MAIN: st_nxt.rdata[7:0] = st_r.main;
        `PRI_OFF_RCTL: st_nxt.rdata[`PRI_B_PRIORITY_MODE_ENABLE] = st_r.priority_mode_enable;
        `PRI_OFF_SECOND: st_nxt.rdata[7:0] = st_r.second;
        `PRI_OFF_STATUS: begin
          st_nxt.rdata[`PRI_B_HIACT] = st_r.hi_act;
          st_nxt.rdata[`PRI_B_LOACT] = st_r.lo_act;
        end
        default: begin
          st_nxt.slverr = 1'b1;
          for (int i = 0; i < PREG_N; i++) begin
            if (paddr == `PRI_OFF_PFLAG + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.rdata[`PRI_PREG_W-1:0] = st_r.pflag[i*`PRI_PREG_W +: `PRI_PREG_W];
              st_nxt.slverr = 1'b0;
            end
            if (paddr == `PRI_OFF_PEN + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.rdata[`PRI_PREG_W-1:0] = st_r.pen[i*`PRI_PREG_W +: `PRI_PREG_W];
              st_nxt.slverr = 1'b0;
            end
            if (paddr == `PRI_OFF_PPRIO + `PRI_ADDR_W'(4 * i)) begin
              st_nxt.rdata[`PRI_PREG_W-1:0] = st_r.pprio[i*`PRI_PREG_W +: `PRI_PREG_W];
              st_nxt.slverr = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_r <= '0;
      st_r.main <= `PRI_RST_MAIN;
      st_r.priority_mode_enable <= 1'b0;
      st_r.second <= `PRI_RST_SECOND;
      st_r.pprio <= {PREG_N{`PRI_RST_PPRIO}};
      st_r.vec_addr <= `PRI_VEC_HIGH;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st_r.rdata;
  assign pslverr = st_r.slverr & psel & penable;
  assign pready = 1'b1;
  assign vec_load = st_r.vec_load;
  assign stack_push = st_r.vec_load;
  assign vec_addr = st_r.vec_addr;
  assign port_b_input = st_r.pb_s2;
  assign wake_req = core_asleep & ((|core_act) | (|p_act));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_int);

  sequence s_hi_take;
    accept && take_hi;
  endsequence

  sequence s_lo_take;
    accept && !take_hi;
  endsequence

  a_hi_vector_addr: assert property (s_hi_take |=> vec_load && vec_addr == 16'h0008)
    else $error("high accept did not load 0008h");
  a_lo_vector_addr: assert property (s_lo_take |=> vec_load && vec_addr == 16'h0018)
    else $error("low accept did not load 0018h");
  a_hi_preempts_lo: assert property (st_r.priority_mode_enable && st_r.lo_act && hi_pend && core_boundary
                                     |=> st_r.hi_act && vec_addr == 16'h0008)
    else $error("high request did not preempt low routine");
  a_compat_one_vec: assert property (!st_r.priority_mode_enable |-> !lo_pend)
    else $error("low vector requested in compatibility mode");
  a_gie_cleared: assert property (s_hi_take ##0 !return_from_irq_instr |=> !st_r.main[7])
    else $error("global enable not cleared on accept");
  a_low_level_global_enable_cleared: assert property (s_lo_take |=> !st_r.main[6] && st_r.lo_act)
    else $error("low enable not cleared on accept");
  a_no_lo_in_hi: assert property (st_r.hi_act |-> !lo_pend)
    else $error("low request pending during high routine");
  a_ret_restores: assert property (return_from_irq_instr && !accept && st_r.hi_act
                                   |=> st_r.main[7] && !st_r.hi_act)
    else $error("return did not restore enable");
  a_pin_latency: assert property ($rose(ext_pin0_in) && st_r.second[6] && !st_r.main[1] && !wr
                                  |-> ##[2:3] st_r.main[1])
    else $error("pin flag late");
  a_timer_flag: assert property (timer0_ovf |=> st_r.main[2])
    else $error("timer flag not set");
  a_periph_flag: assert property (|periph_evt |=> (st_r.pflag & $past(periph_evt)) == $past(periph_evt))
    else $error("peripheral flag not set");
  a_port_change: assert property (pb_mismatch |=> st_r.main[0])
    else $error("port change flag not set");
  a_single_req: assert property (vec_load |-> !$past(vec_load))
    else $error("back to back vector loads");
  a_wake_req: assert property (core_asleep && st_r.main[5] && st_r.main[2] |-> wake_req)
    else $error("no wake on enabled flag");

endmodule

/* File: verilog/pri_params.svh */
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PRI_ADDR_W 12
`define PRI_OFF_MAIN 12'h000
`define PRI_OFF_RCTL 12'h004
`define PRI_OFF_SECOND 12'h008
`define PRI_OFF_STATUS 12'h00C
`define PRI_OFF_PFLAG 12'h010
`define PRI_OFF_PEN 12'h020
`define PRI_OFF_PPRIO 12'h030

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRI_B_HIGH_LEVEL_GLOBAL_ENABLE 7
`define PRI_B_LOW_LEVEL_GLOBAL_ENABLE 6
`define PRI_B_T0IE 5
`define PRI_B_X0IE 4
`define PRI_B_PCIE 3
`define PRI_B_T0IF 2
`define PRI_B_X0IF 1
`define PRI_B_PCIF 0
`define PRI_B_PRIORITY_MODE_ENABLE 7
`define PRI_B_X0EDGE 6
`define PRI_B_T0IP 2
`define PRI_B_PCIP 0
`define PRI_B_HIACT 1
`define PRI_B_LOACT 0

// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define PRI_RST_MAIN 8'h00
`define PRI_RST_SECOND 8'hFF
`define PRI_RST_PPRIO 8'hFF
`define PRI_VEC_HIGH 16'h0008
`define PRI_VEC_LOW 16'h0018
`define PRI_PREG_N 3
`define PRI_PREG_W 8

`endif

/* File: verilog/pri_pkg.sv */
`include "pri_params.svh"

package pri_pkg;

  // Whole state of the controller
  typedef struct packed {
    logic [7:0] main;
    logic priority_mode_enable;
    logic [7:0] second;
    logic [`PRI_PREG_N*`PRI_PREG_W-1:0] pflag;
    logic [`PRI_PREG_N*`PRI_PREG_W-1:0] pen;
    logic [`PRI_PREG_N*`PRI_PREG_W-1:0] pprio;
    logic hi_act;
    logic lo_act;
    logic [1:0] x0_sync;
    logic x0_prev;
    logic [3:0] pb_s1;
    logic [3:0] pb_s2;
    logic [3:0] pb_latch;
    logic vec_load;
    logic [15:0] vec_addr;
    logic [31:0] rdata;
    logic slverr;
  } pri_state_t;

endpackage
